// ===== inc/bss_pkg.sv
// Package for the boot source strap select block.
// Assumes a single 125 MHz core clock domain.
package bss_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Strap bus layout
    localparam int unsigned STRAP_W = 5;
    localparam int unsigned STRAP_B_JTAG_CHAIN = 0;
    localparam int unsigned STRAP_B_SRC0 = 0;
    localparam int unsigned STRAP_B_SRC1 = 1;
    localparam int unsigned STRAP_B_SDSEL = 2;
    localparam int unsigned STRAP_B_JTAGMODE = 3;
    localparam int unsigned STRAP_B_PLL = 4;
    // Card detect select value that routes detection to the fabric pin
    localparam logic [31:0] CD_SEL_FABRIC = 32'h003F_003F;
    localparam logic [31:0] CD_SEL_RESET = 32'h0000_0000;
    // Power sequencing delay between rail steps
    localparam int unsigned SEQ_STEP_US = 100;
    localparam int unsigned SEQ_STEP_CYC = (SEQ_STEP_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Reset stretch after all rails good
    localparam int unsigned RST_HOLD_US = 10;
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int unsigned NUM_RAILS = 3;
    // Cycles after reset before the boot select is taken, so the pin has cleared the filter
    localparam int unsigned STRAP_SETTLE_CYC = 5;

    typedef enum logic [2:0] {
        BSS_SRC_CASC_JTAG,
        BSS_SRC_INDEP_JTAG,
        BSS_SRC_QSPI,
        BSS_SRC_SD,
        BSS_SRC_INVALID
    } bss_src_t;

    typedef enum logic [1:0] {
        BSS_FETCH_NONE,
        BSS_FETCH_SPI,
        BSS_FETCH_SD
    } bss_fetch_t;
endpackage : bss_pkg

// ===== inc/bss_sync_if.sv
// Carrier for one synchronised pin group between the top and its filter.
// Assumes all users share the core clock.
interface bss_sync_if #(parameter int unsigned W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] stable;
    modport filt (input raw, output stable);
    modport user (output raw, input stable);
endinterface : bss_sync_if

// ===== verilog/bss_pin_sync.sv
// Three-stage pin synchroniser; a change counts once stages two and three agree.
// Assumes raw inputs are asynchronous to the core clock.
module bss_pin_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Pin group
    bss_sync_if.filt sif
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] stable_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= sif.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    stable_q[g] <= RST_VAL[g];
                end else if (s2_q[g] == s3_q[g]) begin
                    stable_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate

    assign sif.stable = stable_q;
endmodule : bss_pin_sync

// ===== verilog/bss_boot_ctrl.sv
// Boot source strap select and system controller sequencing.
// Assumes carrier logic drives only the boot select pin; other straps are fixed.
//
// Functional notes
// RULE1 - Five strap bits sampled; top bit enables PLLs, not a source select.
// RULE2 - QSPI and SD encodings differ only in strap bit two.
// RULE3 - Strap bit zero fixed high, bit one fixed low.
// RULE4 - Carrier drives only strap bit two; others left to resistors.
// RULE5 - First stage loader fetched only from SPI flash or SD card.
// RULE6 - SD boot loads everything from card and never touches SPI flash.
// RULE7 - Loader writes both card detect selects to route to fabric pin.
// RULE8 - Without software setup, card detect stays on multiplexed pin zero.
// RULE9 - Host supplies bitstream stripped of preamble, bytes swapped per word.
// RULE10 - Bitstreams with processor built using configuration clock at startup.
// RULE11 - Software writes zero to config control before loading the fabric.
// RULE12 - Controller sequences supplies, makes resets, drives boot straps.
// RULE13 - Controller switches all supplies, except core rails in bypass mode.
// RULE14 - Controller accepts its own code update over I2C.
// RULE15 - Bits zero to two low give JTAG; bit three picks cascade. Code gives independent JTAG when bit three is high, cascade when low.
// RULE16 - Boot select captured only at power on; low picks SD boot.
module bss_boot_ctrl #(
    parameter int unsigned STEP_CYC = bss_pkg::SEQ_STEP_CYC,
    parameter int unsigned HOLD_CYC = bss_pkg::RST_HOLD_CYC
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Board pins
    input wire logic i_mode_sel,
    input wire logic i_pwr_en,
    input wire logic i_sequencing_bypass,
    input wire logic i_reset_in_n,
    input wire logic i_pll_en_strap,
    input wire logic i_jtag_indep,
    input wire logic [bss_pkg::NUM_RAILS-1:0] i_rail_good,
    // Loader side controls
    input wire logic i_cd_sel_wr,
    input wire logic [31:0] i_cd_sel_wdata,
    input wire logic i_cfg_ctrl_clr,
    input wire logic i_sc_update_req,
    // Outputs
    output logic [bss_pkg::STRAP_W-1:0] o_boot_strap,
    output logic [2:0] o_boot_src,
    output logic [1:0] o_loader_fetch,
    output logic o_spi_flash_en,
    output logic [31:0] o_card_detect_select_first,
    output logic [31:0] o_card_detect_select_second,
    output logic o_cd_on_fabric_pin,
    output logic o_cfg_ready,
    output logic [bss_pkg::NUM_RAILS-1:0] o_rail_en,
    output logic o_power_good,
    output logic o_ps_por_n,
    output logic o_periph_rst_n,
    output logic o_sc_update_busy
);
    localparam int unsigned SYNC_W = 7;
    localparam int unsigned CNT_W = $clog2(STEP_CYC + HOLD_CYC + 2);

    typedef enum logic [2:0] {
        SEQ_OFF, SEQ_RAMP, SEQ_HOLD, SEQ_RUN, SEQ_UPDATE
    } bss_seq_t;

    bss_sync_if #(.W(SYNC_W)) pins ();
    assign pins.raw = {i_mode_sel, i_pwr_en, i_sequencing_bypass, i_reset_in_n,
                       i_pll_en_strap, i_jtag_indep, i_sc_update_req};

    // Board resting levels: mode, enable and reset in pulled up, bypass pulled down
    bss_pin_sync #(.W(SYNC_W), .RST_VAL(7'h6_8)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .sif(pins)
    );

    logic mode_s, en_s, byp_s, rstin_s, pll_s, jind_s, upd_s;
    assign {mode_s, en_s, byp_s, rstin_s, pll_s, jind_s, upd_s} = pins.stable;

    function automatic bss_pkg::bss_src_t decode_src(input logic [4:0] s);
        if (s[2:0] == 3'h0) begin
            return s[bss_pkg::STRAP_B_JTAGMODE] ? bss_pkg::BSS_SRC_INDEP_JTAG
                                                : bss_pkg::BSS_SRC_CASC_JTAG; // RULE15
        end
        if (s[bss_pkg::STRAP_B_SRC0] && !s[bss_pkg::STRAP_B_SRC1]) begin
            return s[bss_pkg::STRAP_B_SDSEL] ? bss_pkg::BSS_SRC_SD
                                             : bss_pkg::BSS_SRC_QSPI; // RULE2
        end
        return bss_pkg::BSS_SRC_INVALID;
    endfunction : decode_src

    // Boot select is caught once after power-on; later changes are ignored
    logic latched_q;
    logic sd_boot_q;
    logic [2:0] settle_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            settle_q <= '0;
            latched_q <= 1'b0;
            sd_boot_q <= 1'b0;
        end else if (settle_q != 3'(bss_pkg::STRAP_SETTLE_CYC)) begin
            settle_q <= settle_q + 3'd1;
        end else if (!latched_q) begin
            latched_q <= 1'b1;
            sd_boot_q <= !mode_s; // RULE16
        end
    end

    logic [4:0] strap_d;
    always_comb begin
        strap_d = '0;
        strap_d[bss_pkg::STRAP_B_SRC0] = 1'b1; // RULE3
        strap_d[bss_pkg::STRAP_B_SRC1] = 1'b0; // RULE3
        strap_d[bss_pkg::STRAP_B_SDSEL] = sd_boot_q; // RULE4
        strap_d[bss_pkg::STRAP_B_JTAGMODE] = jind_s;
        strap_d[bss_pkg::STRAP_B_PLL] = pll_s; // RULE1
    end

    bss_pkg::bss_src_t src_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_boot_strap <= '0;
            src_q <= bss_pkg::BSS_SRC_QSPI;
        end else if (latched_q) begin
            o_boot_strap <= strap_d; // RULE12
            src_q <= decode_src(strap_d); // RULE1
        end
    end
    assign o_boot_src = src_q;

    // Power sequencer
    bss_seq_t seq_q;
    logic [CNT_W-1:0] cnt_q;
    logic [1:0] rail_idx_q;
    logic rails_ok;
    assign rails_ok = &i_rail_good;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_q <= SEQ_OFF;
            cnt_q <= '0;
            rail_idx_q <= '0;
        end else begin
            unique case (seq_q)
                SEQ_OFF: begin
                    cnt_q <= '0;
                    rail_idx_q <= '0;
                    if (latched_q && (en_s || byp_s)) begin
                        seq_q <= SEQ_RAMP;
                    end
                end
                SEQ_RAMP: begin
                    if (!en_s && !byp_s) begin
                        seq_q <= SEQ_OFF;
                    end else if (cnt_q == CNT_W'(STEP_CYC - 1)) begin
                        cnt_q <= '0;
                        if (rail_idx_q == 2'(bss_pkg::NUM_RAILS - 1)) begin
                            seq_q <= SEQ_HOLD;
                        end else begin
                            rail_idx_q <= rail_idx_q + 2'd1;
                        end
                    end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                SEQ_HOLD: begin
                    if (!en_s && !byp_s) begin
                        seq_q <= SEQ_OFF;
                    end else if (!rails_ok || !rstin_s) begin
                        cnt_q <= '0;
                    end else if (cnt_q == CNT_W'(HOLD_CYC - 1)) begin
                        seq_q <= SEQ_RUN;
                    end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                SEQ_RUN: begin
                    if (!en_s && !byp_s) begin
                        seq_q <= SEQ_OFF;
                    end else if (upd_s) begin
                        seq_q <= SEQ_UPDATE; // RULE14
                    end else if (!rails_ok || !rstin_s) begin
                        cnt_q <= '0;
                        seq_q <= SEQ_HOLD;
                    end
                end
                SEQ_UPDATE: begin
                    if (!upd_s) begin
                        cnt_q <= '0;
                        seq_q <= SEQ_HOLD; // RULE14
                    end
                end
                default: seq_q <= SEQ_OFF;
            endcase
        end
    end

    // Rail enables: core rails forced on in bypass mode, others sequenced
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rail_en <= '0;
        end else begin
            for (int r = 0; r < bss_pkg::NUM_RAILS; r++) begin
                if (r < 2 && byp_s) begin
                    o_rail_en[r] <= 1'b1; // RULE13
                end else begin
                    o_rail_en[r] <= (seq_q != SEQ_OFF) &&
                        ((seq_q != SEQ_RAMP) || (2'(r) <= rail_idx_q)); // RULE13
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_power_good <= 1'b0;
            o_ps_por_n <= 1'b0;
            o_periph_rst_n <= 1'b0;
            o_sc_update_busy <= 1'b0;
        end else begin
            o_power_good <= rails_ok && (seq_q == SEQ_HOLD || seq_q == SEQ_RUN);
            o_ps_por_n <= (seq_q == SEQ_RUN); // RULE12
            o_periph_rst_n <= (seq_q == SEQ_RUN) && rstin_s; // RULE12
            o_sc_update_busy <= (seq_q == SEQ_UPDATE);
        end
    end

    // Loader fetch path and SPI flash gating
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_loader_fetch <= bss_pkg::BSS_FETCH_NONE;
            o_spi_flash_en <= 1'b0;
        end else begin
            unique case (src_q)
                bss_pkg::BSS_SRC_SD: o_loader_fetch <= bss_pkg::BSS_FETCH_SD; // RULE5
                bss_pkg::BSS_SRC_QSPI: o_loader_fetch <= bss_pkg::BSS_FETCH_SPI; // RULE5
                default: o_loader_fetch <= bss_pkg::BSS_FETCH_NONE;
            endcase
            o_spi_flash_en <= (src_q != bss_pkg::BSS_SRC_SD) && (seq_q == SEQ_RUN); // RULE6
        end
    end

    // Card detect selects stay on the pin-zero default until software writes
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_card_detect_select_first <= bss_pkg::CD_SEL_RESET; // RULE8
            o_card_detect_select_second <= bss_pkg::CD_SEL_RESET; // RULE8
            o_cd_on_fabric_pin <= 1'b0;
        end else if (i_cd_sel_wr) begin
            o_card_detect_select_first <= i_cd_sel_wdata; // RULE7
            o_card_detect_select_second <= i_cd_sel_wdata; // RULE7
            o_cd_on_fabric_pin <= (i_cd_sel_wdata == bss_pkg::CD_SEL_FABRIC);
        end
    end

    // Fabric load is refused until the control word has been cleared once
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg_ready <= 1'b0;
        end else if (i_cfg_ctrl_clr) begin
            o_cfg_ready <= 1'b1; // RULE11
        end
    end

    sequence run_then_por_s;
        seq_q == SEQ_RUN ##1 o_ps_por_n;
    endsequence
    strap_fixed_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
        $past(latched_q) |-> o_boot_strap[1:0] == 2'h1)
        else $error("fixed strap bits wrong");
    sd_no_spi_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE6
        src_q == bss_pkg::BSS_SRC_SD |=> !o_spi_flash_en)
        else $error("SPI flash enabled in SD boot");
    sd_select_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE16
        latched_q && $stable(latched_q) |-> o_boot_strap[bss_pkg::STRAP_B_SDSEL] == sd_boot_q)
        else $error("strap bit two not boot select");
    latch_once_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE16
        $past(latched_q) |-> $stable(sd_boot_q))
        else $error("boot select relatched");
    capture_wait_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE16
        !latched_q && settle_q != 3'(bss_pkg::STRAP_SETTLE_CYC) |=> !latched_q)
        else $error("boot select caught before pin settled");
    bypass_rails_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE13
        byp_s ##1 byp_s |-> o_rail_en[1:0] == 2'h3)
        else $error("core rails off in bypass mode");
    cd_default_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE8
        !i_cd_sel_wr |=> $stable(o_card_detect_select_first))
        else $error("card detect select changed unasked");
    fetch_src_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE5
        src_q == bss_pkg::BSS_SRC_SD [*2] |-> o_loader_fetch == bss_pkg::BSS_FETCH_SD)
        else $error("loader fetched from wrong source");
    por_run_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE12
        seq_q == SEQ_OFF |=> !o_ps_por_n)
        else $error("reset released while off");
    hold_run_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE12
        seq_q == SEQ_HOLD && (en_s || byp_s) && rails_ok && rstin_s
        && cnt_q == CNT_W'(HOLD_CYC - 1) |=> run_then_por_s)
        else $error("hold did not lead into run");
endmodule : bss_boot_ctrl

// ===== tb/bss_carrier_model.sv
// Carrier board logic that drives the module's boot select pin.
// Assumes the pin has a pull-up on the module; released means high.
module bss_carrier_model (
    // Request from the bench
    input wire logic i_sd_boot,
    // Board pin
    output logic o_mode_sel
);
    timeunit 1ns;
    timeprecision 100ps;
    // Only the boot select pin is driven; the other straps stay on resistors
    // Low asks for card boot, otherwise the pin is driven high
    assign o_mode_sel = i_sd_boot ? 1'b0 : 1'b1;
endmodule : bss_carrier_model

// ===== tb/boot_source_strap_select_tb.sv
// Self-checking bench for the boot strap and sequencing controller.
// Assumes one 125 MHz clock; sequencing counts are shortened to 4 and 3.
module boot_source_strap_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic pll;
        logic jind;
        logic sd;
        logic [4:0] strap;
        logic [2:0] src;
        logic [1:0] fetch;
    } bss_tb_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sd_req = 1'b0;
    logic mode_sel;
    logic pwr_en = 1'b0;
    logic bypass = 1'b0;
    logic pll_en = 1'b0;
    logic jtag_indep = 1'b0;
    logic [2:0] rail_good = 3'h0;
    logic cd_wr = 1'b0;
    logic [31:0] cd_wdata = 32'h0000_0000;
    logic cfg_clr = 1'b0;
    logic upd_req = 1'b0;
    logic rst_in_n = 1'b1;
    logic [4:0] strap;
    logic [2:0] src;
    logic [1:0] fetch;
    logic spi_en, cd_fab, cfg_ready, pgood, por_n, periph_n, busy;
    logic [31:0] cd_first, cd_second;
    logic [2:0] rail_en;
    int failures = 0;
    int checks_done = 0;
    // Bit 0 is pulled up and bit 1 down, so JTAG boot can never come out
    bss_tb_row_t rows [4] = '{
        '{1'b0, 1'b0, 1'b0, 5'h01, bss_pkg::BSS_SRC_QSPI, bss_pkg::BSS_FETCH_SPI},
        '{1'b1, 1'b1, 1'b0, 5'h19, bss_pkg::BSS_SRC_QSPI, bss_pkg::BSS_FETCH_SPI},
        '{1'b1, 1'b0, 1'b1, 5'h15, bss_pkg::BSS_SRC_SD, bss_pkg::BSS_FETCH_SD},
        '{1'b0, 1'b1, 1'b1, 5'h0D, bss_pkg::BSS_SRC_SD, bss_pkg::BSS_FETCH_SD}};

    always #4 clk = ~clk;
    // Supplies report good one cycle after being switched on
    always @(posedge clk) rail_good <= rail_en;

    bss_carrier_model u_carrier (.i_sd_boot(sd_req), .o_mode_sel(mode_sel));

    bss_boot_ctrl #(.STEP_CYC(4), .HOLD_CYC(3)) u_dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_mode_sel(mode_sel), .i_pwr_en(pwr_en),
        .i_sequencing_bypass(bypass), .i_reset_in_n(rst_in_n), .i_pll_en_strap(pll_en),
        .i_jtag_indep(jtag_indep), .i_rail_good(rail_good), .i_cd_sel_wr(cd_wr),
        .i_cd_sel_wdata(cd_wdata), .i_cfg_ctrl_clr(cfg_clr), .i_sc_update_req(upd_req),
        .o_boot_strap(strap), .o_boot_src(src), .o_loader_fetch(fetch),
        .o_spi_flash_en(spi_en), .o_card_detect_select_first(cd_first),
        .o_card_detect_select_second(cd_second), .o_cd_on_fabric_pin(cd_fab),
        .o_cfg_ready(cfg_ready), .o_rail_en(rail_en), .o_power_good(pgood),
        .o_ps_por_n(por_n), .o_periph_rst_n(periph_n), .o_sc_update_busy(busy));

    task final_report;
        $display("Checks done: %0d, failures: %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic probe(input int k);
        case (k)
            0: probe = por_n;
            1: probe = (rail_en[1:0] == 2'h3);
            default: probe = busy;
        endcase
    endfunction : probe

    // Bounded wait, sampled at falling edges where outputs are settled
    task automatic wait_out(input int k, input logic v);
        int n;
        n = 0;
        while (probe(k) !== v && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (probe(k) !== v) begin
            failures++;
            $display("MISMATCH at %0t: wait ran out", $time);
            final_report();
        end
    endtask : wait_out

    task do_reset(input logic pll, input logic j, input logic sd);
        @(posedge clk);
        rst_n <= 1'b0;
        pwr_en <= 1'b0;
        bypass <= 1'b0;
        pll_en <= pll;
        jtag_indep <= j;
        sd_req <= sd;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(por_n, 1'b0);
        chk(rail_en, 3'h0);
        chk(cd_first, bss_pkg::CD_SEL_RESET);
        @(posedge clk);
        rst_n <= 1'b1;
        // Boot select is taken only once the pin filter has settled
        repeat (10) @(posedge clk);
        @(negedge clk);
    endtask : do_reset

    task run_seq(input logic exp_spi);
        @(posedge clk);
        pwr_en <= 1'b1;
        wait_out(0, 1'b1);
        chk(rail_en, 3'h7);
        chk(pgood, 1'b1);
        chk(periph_n, 1'b1);
        chk(spi_en, exp_spi);
    endtask : run_seq

    // Two writes on consecutive edges; only the second may remain
    task cd_write2(input logic [31:0] a, input logic [31:0] b);
        @(posedge clk);
        cd_wr <= 1'b1;
        cd_wdata <= a;
        @(posedge clk);
        cd_wdata <= b;
        @(posedge clk);
        cd_wr <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(cd_first, b);
        chk(cd_second, b);
        chk(cd_fab, b == bss_pkg::CD_SEL_FABRIC);
    endtask : cd_write2

    initial begin
        #800000;
        failures++;
        $display("MISMATCH at %0t: run timed out", $time);
        final_report();
    end

    initial begin
        for (int r = 0; r < 4; r++) begin
            do_reset(rows[r].pll, rows[r].jind, rows[r].sd);
            chk(strap, rows[r].strap);
            chk(src, rows[r].src);
            chk(fetch, rows[r].fetch);
            chk(spi_en, 1'b0);
        end
        run_seq(1'b0);
        do_reset(1'b1, 1'b0, 1'b0);
        // Pin pulled low after power-on must not change the source
        @(posedge clk);
        sd_req <= 1'b1;
        repeat (10) @(negedge clk);
        chk(src, bss_pkg::BSS_SRC_QSPI);
        chk(strap, 5'h11);
        run_seq(1'b1);
        // Board reset in drops the processor back to reset until it lifts again
        @(posedge clk);
        rst_in_n <= 1'b0;
        wait_out(0, 1'b0);
        chk(periph_n, 1'b0);
        chk(pgood, 1'b1);
        @(posedge clk);
        rst_in_n <= 1'b1;
        wait_out(0, 1'b1);
        chk(periph_n, 1'b1);
        cd_write2(32'h1234_5678, bss_pkg::CD_SEL_FABRIC);
        cd_write2(bss_pkg::CD_SEL_FABRIC, 32'h0000_0001);
        chk(cfg_ready, 1'b0);
        @(posedge clk);
        // Host streams the word-swapped, preamble-free image on the configuration clock after this
        cfg_clr <= 1'b1;
        @(posedge clk);
        cfg_clr <= 1'b0;
        repeat (4) @(negedge clk);
        chk(cfg_ready, 1'b1);
        @(posedge clk);
        upd_req <= 1'b1;
        wait_out(2, 1'b1);
        @(posedge clk);
        upd_req <= 1'b0;
        wait_out(2, 1'b0);
        do_reset(1'b0, 1'b0, 1'b0);
        @(posedge clk);
        bypass <= 1'b1;
        wait_out(1, 1'b1);
        chk(rail_en[2], 1'b0);
        final_report();
    end
endmodule : boot_source_strap_select_tb
